// *** design/icd_pkg.sv ***
// icd_pkg: shared constants and types of the instruction cycle decoder
// assumes: 14-bit words from program memory, one oscillator clock domain
package icd_pkg;

  // ********************************
  // word layout and timing
  // ********************************
  localparam int          WORD_W         = 14;
  localparam int          OSC_PER_ICYCLE = 4;
  localparam logic [1:0]  Q_LAST         = 2'(OSC_PER_ICYCLE - 1);
  localparam logic [1:0]  Q_RD_SET       = 2'h0;
  localparam logic [1:0]  Q_WR_SET       = 2'h2;
  localparam int          FILE_W         = 7;
  localparam int          DEST_POS       = 7;
  localparam int          BIT_LSB        = 7;
  localparam int          BITSEL_POS     = 11;
  localparam int          PTR_SHORT_POS  = 2;
  localparam int          PTR_LONG_POS   = 6;
  localparam logic [6:0]  IND_ADDR_MASK  = 7'h7e;
  localparam logic [6:0]  IND_ADDR_VAL   = 7'h00;

  // ********************************
  // opcode patterns, value and mask
  // ********************************
  localparam logic [13:0] CTRL_VAL    = 14'h0000;
  localparam logic [13:0] CTRL_MSK    = 14'h3f80;
  localparam logic [13:0] CLRACC_VAL  = 14'h0100;
  localparam logic [13:0] CLRACC_MSK  = 14'h3ffc;
  localparam logic [13:0] EXIT_VAL    = 14'h0008;
  localparam logic [13:0] EXIT_MSK    = 14'h3ffc;
  localparam logic [13:0] LONGJ_VAL   = 14'h2000;
  localparam logic [13:0] LONGJ_MSK   = 14'h3000;
  localparam logic [13:0] EXLIT_VAL   = 14'h3400;
  localparam logic [13:0] RELJ_VAL    = 14'h3200;
  localparam logic [13:0] RELJ_MSK    = 14'h3e00;
  localparam logic [13:0] PTRMOV_VAL  = 14'h0010;
  localparam logic [13:0] PTRMOV_MSK  = 14'h3ff0;
  localparam logic [13:0] PTRIDX_VAL  = 14'h3f00;
  localparam logic [13:0] PTRADD_VAL  = 14'h3100;
  localparam logic [13:0] PTRADD_MSK  = 14'h3f80;
  localparam logic [13:0] DECSKZ_VAL  = 14'h0b00;
  localparam logic [13:0] INCSKZ_VAL  = 14'h0f00;
  localparam logic [13:0] NIB_MSK     = 14'h3f00;
  localparam logic [13:0] ASR_VAL     = 14'h3700;
  localparam logic [13:0] LSL_VAL     = 14'h3500;
  localparam logic [13:0] LSR_VAL     = 14'h3600;
  localparam logic [13:0] ADDC_VAL    = 14'h3d00;
  localparam logic [13:0] SUBB_VAL    = 14'h3b00;
  localparam logic [13:0] BITOP_VAL   = 14'h1000;
  localparam logic [13:0] BITOP_MSK   = 14'h3000;

  // ********************************
  // types
  // ********************************
  typedef enum logic [2:0] {
    ICD_EXEC  = 3'b001,
    ICD_FLUSH = 3'b010,
    ICD_IND   = 3'b100
  } icd_state_t;

  typedef enum logic [2:0] {
    ICD_CAT_BYTE = 3'b001,
    ICD_CAT_BIT  = 3'b010,
    ICD_CAT_LIT  = 3'b100
  } icd_cat_t;

endpackage

// *** design/icd_quarter_gen.sv ***
// icd_quarter_gen: counts oscillator clocks into instruction-cycle quarters
// assumes: free-running oscillator clock, asynchronous active-high reset
`timescale 1ns/10ps
module icd_quarter_gen (
  input  wire logic       i_mclk,
  input  wire logic       i_sys_rst,
  output logic      [1:0] o_quarter
);

  // ********************************
  // quarter counter
  // ********************************
  logic [1:0] quarter_reg;
  logic [1:0] quarter_next;

  assign quarter_next = (quarter_reg == icd_pkg::Q_LAST) ? 2'h0 : quarter_reg + 2'h1;
  assign o_quarter    = quarter_reg;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      quarter_reg <= 2'h0;
    end else begin
      quarter_reg <= quarter_next;
    end
  end

endmodule

// *** design/icd_field_decode.sv ***
// icd_field_decode: pure decode of one 14-bit word into category and fields
// assumes: word is stable while read; no state kept here
`timescale 1ns/10ps
module icd_field_decode (
  input  wire logic [13:0] i_word,
  output logic      [2:0]  o_cat,
  output logic             o_file_op,
  output logic             o_wr_file,
  output logic             o_wr_acc,
  output logic             o_two_cycle,
  output logic             o_skip,
  output logic             o_uses_ind,
  output logic             o_ptr_num
);

  function automatic logic op_match(input logic [13:0] w, input logic [13:0] v,
                                    input logic [13:0] m);
    op_match = ((w & m) == v);
  endfunction

  // ********************************
  // category sort
  // ********************************
  logic ctrl_grp;
  logic clr_acc;
  logic ext_byte;
  logic is_byte;
  logic is_bit;
  logic ptr_short;
  logic ptr_idx;
  logic ptr_add;
  logic ind_file;

  assign ctrl_grp  = op_match(i_word, icd_pkg::CTRL_VAL, icd_pkg::CTRL_MSK);
  assign clr_acc   = op_match(i_word, icd_pkg::CLRACC_VAL, icd_pkg::CLRACC_MSK);
  assign ext_byte  = op_match(i_word, icd_pkg::ASR_VAL, icd_pkg::NIB_MSK)
                   | op_match(i_word, icd_pkg::LSL_VAL, icd_pkg::NIB_MSK)
                   | op_match(i_word, icd_pkg::LSR_VAL, icd_pkg::NIB_MSK)
                   | op_match(i_word, icd_pkg::ADDC_VAL, icd_pkg::NIB_MSK)
                   | op_match(i_word, icd_pkg::SUBB_VAL, icd_pkg::NIB_MSK);
  assign is_byte   = ((i_word[13:12] == 2'h0) & ~ctrl_grp) | ext_byte;
  assign is_bit    = op_match(i_word, icd_pkg::BITOP_VAL, icd_pkg::BITOP_MSK);
  assign o_cat     = is_byte ? icd_pkg::ICD_CAT_BYTE
                   : is_bit ? icd_pkg::ICD_CAT_BIT : icd_pkg::ICD_CAT_LIT;

  // ********************************
  // access and timing class
  // ********************************
  assign ptr_short = op_match(i_word, icd_pkg::PTRMOV_VAL, icd_pkg::PTRMOV_MSK);
  assign ptr_idx   = op_match(i_word, icd_pkg::PTRIDX_VAL, icd_pkg::NIB_MSK);
  assign ptr_add   = op_match(i_word, icd_pkg::PTRADD_VAL, icd_pkg::PTRADD_MSK);
  // clear-accumulator form ignores its low don't-care bits and names no file
  assign o_file_op = (is_byte & ~clr_acc) | is_bit;
  assign ind_file  = o_file_op
                   & ((i_word[6:0] & icd_pkg::IND_ADDR_MASK) == icd_pkg::IND_ADDR_VAL);
  assign o_uses_ind = ind_file | ptr_short | ptr_idx;
  assign o_ptr_num  = ind_file ? i_word[0]
                    : ptr_short ? i_word[icd_pkg::PTR_SHORT_POS]
                    : i_word[icd_pkg::PTR_LONG_POS];
  assign o_wr_file  = (is_byte & ~clr_acc & i_word[icd_pkg::DEST_POS])
                    | (is_bit & ~i_word[icd_pkg::BITSEL_POS]);
  assign o_wr_acc   = is_byte & ~i_word[icd_pkg::DEST_POS];
  assign o_skip     = (is_bit & i_word[icd_pkg::BITSEL_POS])
                    | op_match(i_word, icd_pkg::DECSKZ_VAL, icd_pkg::NIB_MSK)
                    | op_match(i_word, icd_pkg::INCSKZ_VAL, icd_pkg::NIB_MSK);
  assign o_two_cycle = op_match(i_word, icd_pkg::EXIT_VAL, icd_pkg::EXIT_MSK)
                     | op_match(i_word, icd_pkg::LONGJ_VAL, icd_pkg::LONGJ_MSK)
                     | op_match(i_word, icd_pkg::EXLIT_VAL, icd_pkg::NIB_MSK)
                     | op_match(i_word, icd_pkg::RELJ_VAL, icd_pkg::RELJ_MSK);
  // ptr_add only selects a pointer number, it touches no file
  logic unused_add;
  assign unused_add = ptr_add;

endmodule

// *** design/icd_core.sv ***
// icd_core: instruction decode and instruction-cycle sequencing
// assumes: program memory presents the next word on i_instr_word by the
// last quarter of each cycle and holds it while o_cycle_kind shows extra
//
// How it works
// - each instruction arrives as one 14-bit word with opcode and operands
// - words sort into byte, bit, and literal-and-control categories
// - an instruction normally occupies exactly one instruction cycle
// - subroutine calls, direct and computed, take two cycles
// - subroutine and interrupt returns, literal return included, take two cycles
// - jumps and relative branches take two cycles, bit or count skips take two only when taken
// - indirect access while pointer aims at program memory adds one cycle
// - one instruction cycle is four oscillator clocks
// - file operand is a 7-bit address from 0x00 to 0x7f
// - destination bit 0 writes accumulator, 1 writes the file register
// - bit field picks one bit of the addressed 8-bit register
// - pointer number field picks pointer 0 or 1
// - don't-care bits never change behaviour
// - file operands run read, modify, then write per destination
// - the read happens even when the instruction only writes
// - skips take one cycle if not taken, two if taken
`timescale 1ns/10ps
module icd_core (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic [13:0] i_instr_word,
  input  wire logic        i_instr_valid,
  input  wire logic [1:0]  i_ptr_in_prog,
  input  wire logic        i_skip_cond,
  output logic      [1:0]  o_quarter,
  output logic      [2:0]  o_cycle_kind,
  output logic             o_exec_live,
  output logic      [2:0]  o_category,
  output logic      [6:0]  o_file_addr,
  output logic             o_dest_file,
  output logic      [7:0]  o_bit_mask,
  output logic             o_ptr_num,
  output logic      [7:0]  o_lit8,
  output logic      [10:0] o_lit11,
  output logic      [8:0]  o_lit9,
  output logic      [6:0]  o_lit7,
  output logic      [5:0]  o_lit6,
  output logic      [4:0]  o_lit5,
  output logic      [1:0]  o_inc_mode,
  output logic             o_file_rd,
  output logic             o_file_wr,
  output logic             o_acc_wr
);

  function automatic logic [7:0] bit_onehot(input logic [2:0] idx);
    bit_onehot = 8'h01 << idx;
  endfunction

  // ********************************
  // quarter timing
  // ********************************
  logic [1:0] quarter;

  icd_quarter_gen u_quarter (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .o_quarter (quarter)
  );

  assign o_quarter = quarter;

  // ********************************
  // decode of the incoming word
  // ********************************
  logic [2:0] dec_cat;
  logic       dec_file_op;
  logic       dec_wr_file;
  logic       dec_wr_acc;
  logic       dec_two_cycle;
  logic       dec_skip;
  logic       dec_uses_ind;
  logic       dec_ptr_num;

  icd_field_decode u_decode (
    .i_word      (i_instr_word),
    .o_cat       (dec_cat),
    .o_file_op   (dec_file_op),
    .o_wr_file   (dec_wr_file),
    .o_wr_acc    (dec_wr_acc),
    .o_two_cycle (dec_two_cycle),
    .o_skip      (dec_skip),
    .o_uses_ind  (dec_uses_ind),
    .o_ptr_num   (dec_ptr_num)
  );

  // ********************************
  // held instruction class
  // ********************************
  logic       live_reg;
  logic       file_op_reg;
  logic       wr_file_reg;
  logic       wr_acc_reg;
  logic       two_cycle_reg;
  logic       skip_reg;
  logic       uses_ind_reg;
  logic       branch_pend_reg;
  icd_pkg::icd_state_t state_reg;
  icd_pkg::icd_state_t state_next;

  // ********************************
  // cycle sequencing
  // ********************************
  logic cycle_end;
  logic ind_prog;
  logic skip_taken;
  logic flush_due;
  logic capture;

  assign cycle_end  = (quarter == icd_pkg::Q_LAST);
  assign ind_prog   = live_reg & uses_ind_reg & i_ptr_in_prog[o_ptr_num];
  assign skip_taken = live_reg & skip_reg & i_skip_cond;
  assign flush_due  = (live_reg & two_cycle_reg) | skip_taken;
  assign capture    = cycle_end & (state_next != icd_pkg::ICD_IND);

  always_comb begin
    case (state_reg)
      icd_pkg::ICD_EXEC: begin
        if (ind_prog) begin
          state_next = icd_pkg::ICD_IND;
        end else if (flush_due) begin
          state_next = icd_pkg::ICD_FLUSH;
        end else begin
          state_next = icd_pkg::ICD_EXEC;
        end
      end
      icd_pkg::ICD_IND: begin
        if (branch_pend_reg | skip_taken) begin
          state_next = icd_pkg::ICD_FLUSH;
        end else begin
          state_next = icd_pkg::ICD_EXEC;
        end
      end
      icd_pkg::ICD_FLUSH: begin
        state_next = icd_pkg::ICD_EXEC;
      end
      default: begin
        state_next = icd_pkg::ICD_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg       <= icd_pkg::ICD_EXEC;
      branch_pend_reg <= 1'b0;
    end else if (cycle_end) begin
      state_reg       <= state_next;
      branch_pend_reg <= live_reg & two_cycle_reg;
    end
  end

  assign o_cycle_kind = state_reg;

  // word fetched behind a branch or taken skip is held dead, a no-op
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      live_reg <= 1'b0;
    end else if (capture) begin
      live_reg <= i_instr_valid & (state_next != icd_pkg::ICD_FLUSH);
    end
  end

  assign o_exec_live = live_reg;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      file_op_reg   <= 1'b0;
      wr_file_reg   <= 1'b0;
      wr_acc_reg    <= 1'b0;
      two_cycle_reg <= 1'b0;
      skip_reg      <= 1'b0;
      uses_ind_reg  <= 1'b0;
    end else if (capture) begin
      file_op_reg   <= dec_file_op;
      wr_file_reg   <= dec_wr_file;
      wr_acc_reg    <= dec_wr_acc;
      two_cycle_reg <= dec_two_cycle;
      skip_reg      <= dec_skip;
      uses_ind_reg  <= dec_uses_ind;
    end
  end

  // ********************************
  // operand fields
  // ********************************
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_category  <= icd_pkg::ICD_CAT_LIT;
      o_file_addr <= 7'h00;
      o_dest_file <= 1'b0;
      o_bit_mask  <= 8'h00;
      o_ptr_num   <= 1'b0;
      o_lit8      <= 8'h00;
      o_lit11     <= 11'h000;
      o_lit9      <= 9'h000;
      o_lit7      <= 7'h00;
      o_lit6      <= 6'h00;
      o_lit5      <= 5'h00;
      o_inc_mode  <= 2'h0;
    end else if (capture) begin
      o_category  <= dec_cat;
      o_file_addr <= i_instr_word[icd_pkg::FILE_W-1:0];
      o_dest_file <= i_instr_word[icd_pkg::DEST_POS];
      o_bit_mask  <= bit_onehot(i_instr_word[icd_pkg::BIT_LSB+2:icd_pkg::BIT_LSB]);
      o_ptr_num   <= dec_ptr_num;
      o_lit8      <= i_instr_word[7:0];
      o_lit11     <= i_instr_word[10:0];
      o_lit9      <= i_instr_word[8:0];
      o_lit7      <= i_instr_word[6:0];
      o_lit6      <= i_instr_word[5:0];
      o_lit5      <= i_instr_word[4:0];
      o_inc_mode  <= i_instr_word[1:0];
    end
  end

  // ********************************
  // read-modify-write strobes
  // ********************************
  logic exec_now;
  logic rd_next;
  logic wr_next;
  logic acc_next;

  assign exec_now = live_reg & (state_reg == icd_pkg::ICD_EXEC);
  assign rd_next  = exec_now & file_op_reg & (quarter == icd_pkg::Q_RD_SET);
  assign wr_next  = exec_now & wr_file_reg & (quarter == icd_pkg::Q_WR_SET);
  assign acc_next = exec_now & wr_acc_reg & (quarter == icd_pkg::Q_WR_SET);

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_file_rd <= 1'b0;
      o_file_wr <= 1'b0;
      o_acc_wr  <= 1'b0;
    end else begin
      o_file_rd <= rd_next;
      o_file_wr <= wr_next;
      o_acc_wr  <= acc_next;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  quarter_seq_a: assert property (
    (o_quarter == 2'h0) |=> (o_quarter == 2'h1) ##1 (o_quarter == 2'h2)
      ##1 (o_quarter == 2'h3) ##1 (o_quarter == 2'h0))
    else $error("quarter counter left its four-clock sequence");

  single_cycle_a: assert property (
    (cycle_end && state_reg == icd_pkg::ICD_EXEC && !ind_prog && !flush_due)
      |=> (state_reg == icd_pkg::ICD_EXEC) [*4])
    else $error("plain instruction did not finish in one cycle");

  branch_two_a: assert property (
    (cycle_end && state_reg == icd_pkg::ICD_EXEC && live_reg && two_cycle_reg && !ind_prog)
      |=> (state_reg == icd_pkg::ICD_FLUSH) [*4] ##1 (state_reg == icd_pkg::ICD_EXEC))
    else $error("call, return or jump did not take two cycles");

  skip_taken_a: assert property (
    (cycle_end && state_reg == icd_pkg::ICD_EXEC && skip_taken && !ind_prog)
      |=> (state_reg == icd_pkg::ICD_FLUSH) && !o_exec_live)
    else $error("taken skip did not add a flush cycle");

  indirect_extra_a: assert property (
    (cycle_end && state_reg == icd_pkg::ICD_EXEC && ind_prog)
      |=> (state_reg == icd_pkg::ICD_IND) && $stable(o_file_addr) [*4])
    else $error("program-memory indirect access lacked its extra cycle");

  flush_dead_a: assert property (
    (state_reg == icd_pkg::ICD_FLUSH) |-> !o_file_wr && !o_acc_wr && !rd_next)
    else $error("discarded instruction touched a register");

  rmw_order_a: assert property (
    o_file_wr |-> $past(o_file_rd, 2))
    else $error("file write without its read two clocks before");

  read_always_a: assert property (
    (exec_now && file_op_reg && wr_file_reg && quarter == icd_pkg::Q_RD_SET)
      |=> o_file_rd ##2 o_file_wr)
    else $error("write-only file operation skipped its read");

  dest_route_a: assert property (
    o_acc_wr |-> !o_file_wr && !o_dest_file)
    else $error("accumulator result also routed to the file");

  bit_mask_a: assert property (
    capture |=> $onehot(o_bit_mask)
      && o_bit_mask == (8'h01 << $past(i_instr_word[9:7])))
    else $error("bit select does not match the bit field");

  file_addr_a: assert property (
    capture |=> o_file_addr == $past(i_instr_word[6:0]))
    else $error("file address not taken from the low seven bits");

  branch_cov: cover property (state_reg == icd_pkg::ICD_EXEC ##1
    state_reg == icd_pkg::ICD_FLUSH);
  indirect_cov: cover property (state_reg == icd_pkg::ICD_IND);
  ind_flush_cov: cover property (state_reg == icd_pkg::ICD_IND ##4
    state_reg == icd_pkg::ICD_FLUSH);
  rmw_cov: cover property (o_file_rd ##2 o_file_wr);

endmodule

// *** verif/icd_prog_model.sv ***
// icd_prog_model: program memory presenting instruction words to the core
// assumes: bench sets the next word before quarter 2; one clock domain
`timescale 1ns/10ps
module icd_prog_model (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic [1:0]  i_quarter,
  input  wire logic [2:0]  i_cycle_kind,
  input  wire logic [13:0] i_next_word,
  input  wire logic        i_next_valid,
  output logic      [13:0] o_instr_word,
  output logic             o_instr_valid
);
  // ********************************
  // fetch hold
  // ********************************
  logic [14:0] held_reg;
  wire         show_word;

  assign show_word = (i_quarter == 2'h3) || (i_cycle_kind == 3'b100);

  // whole word latched once per cycle, kept through an extra cycle
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      held_reg <= 15'h0000;
    end else if (i_quarter == 2'h2 && i_cycle_kind != 3'b100) begin
      held_reg <= {i_next_valid, i_next_word};
    end
  end

  // outside the sampled span the lines carry an inverted pattern
  assign {o_instr_valid, o_instr_word} = show_word ? held_reg : ~held_reg;
endmodule

// *** verif/icd_core_bench.sv ***
// icd_core_bench: scenario tests of the instruction cycle decoder
// assumes: icd_pkg, icd_core and icd_prog_model compiled before this file
`timescale 1ns/10ps
module icd_core_bench;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [13:0] i_instr_word;
  logic        i_instr_valid;
  logic [1:0]  i_ptr_in_prog = 2'h0;
  logic        i_skip_cond = 1'b0;
  logic [13:0] nxt_word = 14'h0000;
  logic        nxt_valid = 1'b1;
  logic [1:0]  o_quarter;
  logic [2:0]  o_cycle_kind, o_category, s_cat;
  logic        o_exec_live, o_dest_file, o_ptr_num, o_file_rd, o_file_wr, o_acc_wr;
  logic [6:0]  o_file_addr, s_addr;
  logic [7:0]  o_bit_mask, o_lit8, s_mask, s_lit8;
  logic [10:0] o_lit11, s_lit11;
  logic [6:0]  o_lit7;
  logic [5:0]  o_lit6;
  logic [4:0]  o_lit5;
  logic [1:0]  o_inc_mode;
  logic [8:0]  o_lit9, s_lit9, k_seq;
  logic        s_dest, s_ptr, s_live, f_live;
  logic [3:0]  n_rd, n_wr, n_acc;
  int          n_cyc, mismatches = 0, num_checks = 0;
  logic [13:0] tbl [8] = '{14'h2123, 14'h000a, 14'h0008, 14'h0009,
                           14'h34c3, 14'h2a5b, 14'h3355, 14'h000b};

  icd_core i_icd_core (.i_mclk, .i_sys_rst, .i_instr_word, .i_instr_valid, .i_ptr_in_prog,
    .i_skip_cond, .o_quarter, .o_cycle_kind, .o_exec_live, .o_category, .o_file_addr,
    .o_dest_file, .o_bit_mask, .o_ptr_num, .o_lit8, .o_lit11, .o_lit9, .o_lit7,
    .o_lit6, .o_lit5, .o_inc_mode, .o_file_rd, .o_file_wr, .o_acc_wr);
  icd_prog_model i_icd_prog_model (.i_mclk, .i_sys_rst, .i_quarter(o_quarter),
    .i_cycle_kind(o_cycle_kind), .i_next_word(nxt_word), .i_next_valid(nxt_valid),
    .o_instr_word(i_instr_word), .o_instr_valid(i_instr_valid));

  always #50 i_mclk = ~i_mclk;

  // ********************************
  // run control
  // ********************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_run(input int n, input logic [8:0] ks, input logic [3:0] r, w, a);
    chk(16'(n_cyc), 16'(n));
    chk({7'h0, k_seq}, {7'h0, ks});
    if (r !== 4'hf) chk({12'h0, n_rd}, {12'h0, r});
    if (w !== 4'hf) chk({12'h0, n_wr}, {12'h0, w});
    if (a !== 4'hf) chk({12'h0, n_acc}, {12'h0, a});
  endtask

  // one instruction: word w, then nw fetched behind it
  task automatic run(input logic [13:0] w, input logic v, sk, input logic [1:0] pp,
                     input logic [13:0] nw);
    @(posedge i_mclk iff o_quarter == 2'h1);
    nxt_word <= w;
    nxt_valid <= v;
    i_skip_cond <= sk;
    i_ptr_in_prog <= pp;
    @(posedge i_mclk iff o_quarter == 2'h3);
    #1;
    {s_cat, s_addr, s_dest, s_mask, s_ptr, s_live} =
      {o_category, o_file_addr, o_dest_file, o_bit_mask, o_ptr_num, o_exec_live};
    {s_lit8, s_lit11, s_lit9} = {o_lit8, o_lit11, o_lit9};
    {n_rd, n_wr, n_acc, k_seq, f_live} = 22'h0;
    n_cyc = 0;
    do begin
      k_seq = {k_seq[5:0], o_cycle_kind};
      if (n_cyc == 1) f_live = o_exec_live;
      n_cyc++;
      for (int q = 0; q < 4; q++) begin
        n_rd += {3'h0, o_file_rd};
        n_wr += {3'h0, o_file_wr};
        n_acc += {3'h0, o_acc_wr};
        @(posedge i_mclk);
        if (q == 1) nxt_word <= (n_cyc == 1) ? nw : 14'h0000;
        if (q == 1) nxt_valid <= 1'b1;
        #1;
      end
    end while (o_cycle_kind !== 3'b001 && n_cyc < 4);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    repeat (5) @(posedge i_mclk);
    #1;
    chk({4'h0, o_cycle_kind, o_category, o_quarter, o_file_rd, o_file_wr, o_acc_wr,
         o_exec_live}, 16'h0300);
    @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    for (int i = 1; i <= 8; i++) begin
      @(posedge i_mclk);
      #1;
      chk({14'h0, o_quarter}, 16'(i % 4));
    end
    $display("test reset done");
  endtask

  task automatic t_byte();
    run(14'h07ff, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h1, 4'h1, 4'h0);
    chk({5'h0, s_live, s_cat, s_addr}, {5'h0, 1'b1, 3'b001, 7'h7f});
    chk({15'h0, s_dest}, 16'h0001);
    run(14'h077f, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h1, 4'h0, 4'h1);
    run(14'h00a5, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h1, 4'h1, 4'h0);
    chk({9'h0, s_addr}, 16'h0025);
    $display("test byte done");
  endtask

  task automatic t_bit();
    for (int b = 0; b < 8; b++) begin
      run(14'h1423 | (14'(b) << 7), 1'b1, 1'b0, 2'h0, 14'h0000);
      chk_run(1, 9'h001, 4'h1, 4'h1, 4'h0);
      chk({5'h0, s_cat, s_mask}, {5'h0, 3'b010, 8'h01 << b});
    end
    $display("test bit done");
  endtask

  task automatic t_lit();
    run(14'h30a5, 1'b1, 1'b0, 2'h0, 14'h317b);
    chk_run(1, 9'h001, 4'h0, 4'h0, 4'hf);
    chk({5'h0, s_cat, s_lit8}, {5'h0, 3'b100, 8'ha5});
    chk({3'h0, o_lit7, o_lit6}, {3'h0, 7'h7b, 6'h3b});
    chk({9'h0, o_lit5, o_inc_mode}, {9'h0, 5'h1b, 2'h3});
    run(14'h0100, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h0, 4'h0, 4'h1);
    run(14'h0103, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h0, 4'h0, 4'h1);
    run(14'h07ff, 1'b0, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h0, 4'h0, 4'h0);
    $display("test literal done");
  endtask

  task automatic t_branch();
    foreach (tbl[i]) begin
      run(tbl[i], 1'b1, 1'b0, 2'h0, 14'h07ff);
      chk_run(2, 9'h00a, 4'h0, 4'h0, 4'hf);
      chk({15'h0, f_live}, 16'h0000);
    end
    run(14'h2123, 1'b1, 1'b0, 2'h0, 14'h07ff);
    chk({5'h0, s_lit11}, 16'h0123);
    run(14'h34c3, 1'b1, 1'b0, 2'h0, 14'h07ff);
    chk_run(2, 9'h00a, 4'h0, 4'h0, 4'hf);
    run(14'h3355, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk({7'h0, s_lit9}, 16'h0155);
    $display("test branch done");
  endtask

  task automatic t_skip();
    run(14'h1823, 1'b1, 1'b0, 2'h0, 14'h07ff);
    chk_run(1, 9'h001, 4'h1, 4'h0, 4'h0);
    run(14'h1823, 1'b1, 1'b1, 2'h0, 14'h07ff);
    chk_run(2, 9'h00a, 4'h1, 4'h0, 4'h0);
    run(14'h1c23, 1'b1, 1'b1, 2'h0, 14'h07ff);
    chk_run(2, 9'h00a, 4'h1, 4'h0, 4'h0);
    run(14'h0ba3, 1'b1, 1'b1, 2'h0, 14'h07ff);
    chk_run(2, 9'h00a, 4'h1, 4'h1, 4'h0);
    run(14'h0fa3, 1'b1, 1'b0, 2'h0, 14'h0000);
    chk_run(1, 9'h001, 4'h1, 4'h1, 4'h0);
    $display("test skip done");
  endtask

  task automatic t_ind();
    run(14'h0800, 1'b1, 1'b0, 2'h1, 14'h07ff);
    chk_run(2, 9'h00c, 4'h1, 4'h0, 4'h1);
    chk({15'h0, s_ptr}, 16'h0000);
    chk({9'h0, o_file_addr}, 16'h007f);
    run(14'h0801, 1'b1, 1'b0, 2'h2, 14'h0000);
    chk_run(2, 9'h00c, 4'h1, 4'h0, 4'h1);
    chk({15'h0, s_ptr}, 16'h0001);
    run(14'h0801, 1'b1, 1'b0, 2'h1, 14'h0000);
    chk_run(1, 9'h001, 4'h1, 4'h0, 4'h1);
    run(14'h0b80, 1'b1, 1'b1, 2'h1, 14'h07ff);
    chk_run(3, 9'h062, 4'h1, 4'h1, 4'h0);
    $display("test indirect done");
  endtask

  initial begin
    t_reset();
    t_byte();
    t_bit();
    t_lit();
    t_branch();
    t_skip();
    t_ind();
    end_of_test();
  end

  // about 40 instructions of up to 16 clocks each fit well inside this span
  initial begin
    #2000000;
    mismatches++;
    end_of_test();
  end
endmodule
